/* File: logic/flash_seq_map.svh */
// Register offsets, command codes, status bit positions and timing counts of the sequencer
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// ----------------------------------------------------------------------------
// Wishbone register byte offsets
// ----------------------------------------------------------------------------
`define REG_CMD_ADDR 8'h00
`define REG_CMD_DATA 8'h04
`define REG_STATUS 8'h08
`define REG_CTRL 8'h0c
`define REG_LOCK_SEL 8'h10
`define REG_LOCK 8'h14
`define REG_READ_ADDR 8'h18
`define REG_READ_OK 8'h1c
`define REG_BUF_IDX 8'h20
`define REG_BUF_DATA 8'h24

// ----------------------------------------------------------------------------
// Flash address layout (word addresses)
// ----------------------------------------------------------------------------
`define ADDR_W 24
`define SECT_LSB 17
`define SECT_W 7
`define NUM_SECT 128
`define LINE_LSB 8
`define LINE_W 16
`define UNLOCK_ADDR_W 12
`define BLANK_OFS_W 17

// ----------------------------------------------------------------------------
// Command addresses and codes
// ----------------------------------------------------------------------------
`define UNLOCK1_ADDR 12'h555
`define UNLOCK2_ADDR 12'h2aa
`define BLANK_ADDR 17'h00555
`define UNLOCK1_DATA 16'h00aa
`define UNLOCK2_DATA 16'h0055
`define CMD_BUF_LOAD 16'h0025
`define CMD_BUF_CONFIRM 16'h0029
`define CMD_BLANK_CHECK 16'h0033
`define CMD_STATUS_READ 16'h0070
`define CMD_PROG_SUSPEND 16'h00b0
`define CMD_PROG_RESUME 16'h0030
`define CMD_ERASE_SETUP 16'h0080
`define CMD_CHIP_ERASE 16'h0010
`define CMD_ERASE_VERIFY 16'h00d0
`define CMD_SET_EXIT 16'h00f0
`define CMD_LOAD_ICR 16'h0019
`define CMD_LOAD_ISR 16'h001c
`define MAX_WORD_COUNT 16'h00ff
`define ERASED_WORD 16'hffff

// ----------------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------------
`define SR_READY 7
`define SR_ERASE_FAIL 5
`define SR_PROG_FAIL 4
`define SR_BUF_ABORT 3
`define SR_PROG_SUSP 2
`define SR_LOCK 1
`define SR_ERASE_OK 0

// ----------------------------------------------------------------------------
// Timing: figures in ns, converted to cycles of the 25 MHz clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define SUSPEND_LATENCY_NS 200
`define ERASE_VERIFY_NS 320
`define RESET_RECOVERY_NS 200
`define WORD_PROGRAM_NS 640
`define BLANK_CHECK_NS 320
`define SECTOR_PHASE_NS 160
`define SUSPEND_LATENCY_CYC 16'(`SUSPEND_LATENCY_NS / `CLK_PERIOD_NS)
`define ERASE_VERIFY_CYC 16'((`ERASE_VERIFY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOVERY_CYC 16'((`RESET_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WORD_PROGRAM_CYC 16'((`WORD_PROGRAM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_CHECK_CYC 16'((`BLANK_CHECK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECTOR_PHASE_CYC 16'((`SECTOR_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: logic/flash_seq_pkg.sv */
// Types shared by the flash program and erase sequencer
package flash_seq_pkg;

	// Controller states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_UNLK1 = 4'h1,
		ST_UNLK2 = 4'h2,
		ST_BUF_CNT = 4'h3,
		ST_BUF_LOAD = 4'h4,
		ST_BUF_CONF = 4'h5,
		ST_PROG = 4'h6,
		ST_SUSP_WAIT = 4'h7,
		ST_PSUSP = 4'h8,
		ST_SETUP = 4'h9,
		ST_SETUP_U1 = 4'ha,
		ST_SETUP_U2 = 4'hb,
		ST_CHIP_ERASE = 4'hc,
		ST_BLANK = 4'hd,
		ST_VERIFY = 4'he,
		ST_RECOVER = 4'hf
	} seq_state_e;

	// Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;

	// Complete state of the sequencer except the program buffer words
	typedef struct packed {
		seq_state_e state;
		logic [1:0] phase;
		logic [15:0] timer;
		logic [6:0] sector;
		logic [15:0] line;
		logic [7:0] widx;
		logic [8:0] remain;
		logic [7:0] count;
		logic [255:0] valid;
		logic [6:0] sr;
		logic [127:0] dirty;
		logic [127:0] erase_ok;
		logic [127:0] vlock;
		logic [127:0] plock;
		logic [23:0] cmd_addr;
		logic erase_susp;
		logic alternate_space_overlay;
		logic [6:0] esus_sector;
		logic [6:0] lock_sel;
		logic [23:0] read_addr;
		logic [7:0] buf_idx;
		logic ack;
		logic [31:0] dat;
	} seq_regs_s;

endpackage

/* File: logic/flash_program_erase_sequencer.sv */
// Embedded algorithm sequencer: buffered program, suspend/resume, blank check, verify, chip erase
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "flash_seq_map.svh"

module flash_program_erase_sequencer
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire flash_seq_pkg::wb_req_s wb_req_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic ready_o
);
	import flash_seq_pkg::*;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Sector index of a word address
	function automatic logic [`SECT_W-1:0] sect_of(input logic [`ADDR_W-1:0] a);
		sect_of = a[`SECT_LSB +: `SECT_W];
	endfunction

	// Line index of a word address
	function automatic logic [`LINE_W-1:0] line_of(input logic [`ADDR_W-1:0] a);
		line_of = a[`LINE_LSB +: `LINE_W];
	endfunction

	// Byte-lane merge of a bus write into a register image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		merge = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// Reset image: all control state starts from constants
	localparam seq_regs_s RESET_ST = '{
		state: ST_RECOVER, phase: 2'h0, timer: `RESET_RECOVERY_CYC, sector: 7'h00,
		line: 16'h0000, widx: 8'h00, remain: 9'h000, count: 8'h00, valid: '0, sr: 7'h00,
		dirty: '0, erase_ok: '1, vlock: '0, plock: '0, cmd_addr: 24'h000000,
		erase_susp: 1'b0, alternate_space_overlay: 1'b0, esus_sector: 7'h00, lock_sel: 7'h00,
		read_addr: 24'h000000, buf_idx: 8'h00, ack: 1'b0, dat: 32'h00000000};

	seq_regs_s st_reg; // Registered state
	seq_regs_s st_next; // Next state
	logic [15:0] buf_mem [0:255]; // Program buffer words
	logic access; // New bus cycle this clock
	logic wr; // Write access
	logic cmd_fire; // Command word written
	logic [`ADDR_W-1:0] ca; // Command address
	logic [15:0] cd; // Command data
	logic sect_hit; // Command targets the held sector
	logic ready; // Status ready bit
	logic read_ok; // Array read at read_addr is serviceable
	logic locked; // Held sector is protected
	logic buf_we; // Buffer word write strobe
	logic [31:0] wmerge; // Merged write data
	logic [7:0] sr_full; // Status word seen by software

	// ------------------------------------------------------------------------
	// Bus decode and status view
	// ------------------------------------------------------------------------
	// One access per request: the ack flop blocks the repeat cycle
	assign access = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
	assign wr = access && wb_req_i.we;
	assign cmd_fire = wr && (wb_req_i.adr == `REG_CMD_DATA);
	assign ca = st_reg.cmd_addr;
	assign cd = wb_req_i.dat[15:0];
	assign sect_hit = sect_of(ca) == st_reg.sector;
	assign locked = st_reg.vlock[st_reg.sector] || st_reg.plock[st_reg.sector];
	assign wmerge = merge(32'h00000000, wb_req_i.dat, wb_req_i.sel);
	// Busy while any algorithm runs, including the post-reset recovery
	assign ready = !(st_reg.state inside {ST_PROG, ST_SUSP_WAIT, ST_CHIP_ERASE, ST_BLANK,
		ST_VERIFY, ST_RECOVER});
	assign sr_full = {ready, st_reg.sr};
	// Suspended line and erase-suspended sector are off limits to reads
	assign read_ok = !((st_reg.state == ST_PSUSP) &&
		(line_of(st_reg.read_addr) == st_reg.line)) &&
		!(st_reg.erase_susp && (sect_of(st_reg.read_addr) == st_reg.esus_sector)) &&
		!(st_reg.state inside {ST_BLANK, ST_CHIP_ERASE});

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	// Bus registers and the command sequencer share one next-state image
	always_comb
	begin
		st_next = st_reg;
		buf_we = 1'b0;
		st_next.ack = access;
		st_next.dat = 32'h00000000;
		// Register reads; unmapped offsets answer zero
		if (access && !wb_req_i.we)
		begin
			unique case (wb_req_i.adr)
				`REG_CMD_ADDR: st_next.dat = {8'h00, st_reg.cmd_addr};
				`REG_STATUS: st_next.dat = {24'h000000, sr_full};
				`REG_CTRL: st_next.dat = {17'h00000, st_reg.esus_sector, 6'h00, st_reg.alternate_space_overlay,
					st_reg.erase_susp};
				`REG_LOCK_SEL: st_next.dat = {25'h0000000, st_reg.lock_sel};
				`REG_LOCK: st_next.dat = {30'h00000000, st_reg.plock[st_reg.lock_sel],
					st_reg.vlock[st_reg.lock_sel]};
				`REG_READ_ADDR: st_next.dat = {8'h00, st_reg.read_addr};
				`REG_READ_OK: st_next.dat = {24'h000000, st_reg.state, 3'h0, read_ok};
				`REG_BUF_IDX: st_next.dat = {24'h000000, st_reg.buf_idx};
				`REG_BUF_DATA: st_next.dat = {16'h0000, st_reg.valid[st_reg.buf_idx] ?
					buf_mem[st_reg.buf_idx] : `ERASED_WORD};
				default: st_next.dat = 32'h00000000;
			endcase
		end
		// Plain register writes
		if (wr)
		begin
			unique case (wb_req_i.adr)
				`REG_CMD_ADDR: st_next.cmd_addr = 24'(merge({8'h00, st_reg.cmd_addr},
					wb_req_i.dat, wb_req_i.sel));
				`REG_CTRL:
				begin
					st_next.erase_susp = wmerge[0];
					st_next.esus_sector = wmerge[14:8];
					// Overlay entry refused while programming is suspended
					if (!(st_reg.state inside {ST_SUSP_WAIT, ST_PSUSP}) || !wmerge[1])
						st_next.alternate_space_overlay = wmerge[1];
				end
				`REG_LOCK_SEL: st_next.lock_sel = wmerge[6:0];
				`REG_LOCK:
				begin
					st_next.vlock[st_reg.lock_sel] = wmerge[0];
					st_next.plock[st_reg.lock_sel] = wmerge[1];
				end
				`REG_READ_ADDR: st_next.read_addr = wmerge[23:0];
				`REG_BUF_IDX: st_next.buf_idx = wmerge[7:0];
				default: ;
			endcase
		end
		// Command sequencer
		unique case (st_reg.state)
			ST_RECOVER:
			begin
				// Hold busy for the reset recovery time
				if (st_reg.timer == 16'h0000)
					st_next.state = ST_IDLE;
				else
					st_next.timer = st_reg.timer - 16'h0001;
			end
			ST_IDLE:
			begin
				if (cmd_fire)
				begin
					if (cd == `UNLOCK1_DATA && ca[`UNLOCK_ADDR_W-1:0] == `UNLOCK1_ADDR)
						st_next.state = ST_UNLK1;
					else if (cd == `CMD_BLANK_CHECK &&
						ca[`BLANK_OFS_W-1:0] == `BLANK_ADDR)
					begin
						st_next.state = ST_BLANK;
						st_next.sector = sect_of(ca);
						st_next.timer = `BLANK_CHECK_CYC;
					end
					else if (cd == `CMD_ERASE_VERIFY)
					begin
						st_next.state = ST_VERIFY;
						st_next.sector = sect_of(ca);
						st_next.timer = `ERASE_VERIFY_CYC;
					end
				end
			end
			ST_UNLK1:
			begin
				// Any other write drops the unlock
				if (cmd_fire)
					st_next.state = (cd == `UNLOCK2_DATA &&
						ca[`UNLOCK_ADDR_W-1:0] == `UNLOCK2_ADDR) ? ST_UNLK2 : ST_IDLE;
			end
			ST_UNLK2:
			begin
				if (cmd_fire)
				begin
					st_next.state = ST_IDLE;
					if (cd == `CMD_BUF_LOAD)
					begin
						st_next.state = ST_BUF_CNT;
						st_next.sector = sect_of(ca);
						st_next.valid = '0;
					end
					else if (cd == `CMD_ERASE_SETUP)
						st_next.state = ST_SETUP;
				end
			end
			ST_BUF_CNT:
			begin
				if (cmd_fire)
				begin
					// Oversized count or wrong sector aborts at once
					if (!sect_hit || cd > `MAX_WORD_COUNT)
					begin
						st_next.state = ST_IDLE;
						st_next.sr[`SR_PROG_FAIL] = 1'b1;
						st_next.sr[`SR_BUF_ABORT] = 1'b1;
					end
					else
					begin
						st_next.state = ST_BUF_LOAD;
						st_next.count = cd[7:0];
						st_next.remain = {1'b0, cd[7:0]} + 9'h001;
						st_next.phase = 2'h0;
					end
				end
			end
			ST_BUF_LOAD:
			begin
				if (cmd_fire)
				begin
					// First pair picks the line, later pairs must follow it
					if ((st_reg.phase == 2'h0) ? !sect_hit :
						(line_of(ca) != st_reg.line || ca[7:0] != st_reg.widx + 8'h01))
					begin
						st_next.state = ST_IDLE;
						st_next.sr[`SR_PROG_FAIL] = 1'b1;
						st_next.sr[`SR_BUF_ABORT] = 1'b1;
					end
					else
					begin
						buf_we = 1'b1;
						st_next.phase = 2'h1;
						st_next.line = line_of(ca);
						st_next.widx = ca[7:0];
						st_next.valid[ca[7:0]] = 1'b1;
						st_next.remain = st_reg.remain - 9'h001;
						if (st_reg.remain == 9'h001)
							st_next.state = ST_BUF_CONF;
					end
				end
			end
			ST_BUF_CONF:
			begin
				if (cmd_fire)
				begin
					st_next.state = ST_IDLE;
					if (cd != `CMD_BUF_CONFIRM || !sect_hit)
					begin
						st_next.sr[`SR_PROG_FAIL] = 1'b1;
						st_next.sr[`SR_BUF_ABORT] = 1'b1;
					end
					else if (locked)
					begin
						st_next.sr[`SR_PROG_FAIL] = 1'b1;
						st_next.sr[`SR_LOCK] = 1'b1;
					end
					else
					begin
						// Accepted: clear old failure and go busy
						st_next.state = ST_PROG;
						st_next.sr[`SR_PROG_FAIL] = 1'b0;
						st_next.sr[`SR_BUF_ABORT] = 1'b0;
						st_next.sr[`SR_LOCK] = 1'b0;
						st_next.remain = {1'b0, st_reg.count};
						st_next.timer = `WORD_PROGRAM_CYC;
					end
				end
			end
			ST_PROG:
			begin
				// Progress survives suspends: timers are only paused
				if (cmd_fire && cd == `CMD_PROG_SUSPEND && !st_reg.alternate_space_overlay)
				begin
					st_next.state = ST_SUSP_WAIT;
					st_next.phase = 2'h1;
				end
				else if (st_reg.timer != 16'h0000)
					st_next.timer = st_reg.timer - 16'h0001;
				else if (st_reg.remain != 9'h000)
				begin
					st_next.remain = st_reg.remain - 9'h001;
					st_next.timer = `WORD_PROGRAM_CYC;
				end
				else
				begin
					st_next.state = ST_IDLE;
					st_next.dirty[st_reg.sector] = 1'b1;
				end
			end
			ST_SUSP_WAIT:
			begin
				// Latency counted in phase to keep the word timer intact
				// Phase walks from 1 and stops at 3, so the halt stays inside the limit
				if ({14'h0000, st_reg.phase} + 16'h0001 >= `SUSPEND_LATENCY_CYC ||
					st_reg.phase == 2'h3)
				begin
					st_next.state = ST_PSUSP;
					st_next.sr[`SR_PROG_SUSP] = 1'b1;
				end
				else
					st_next.phase = st_reg.phase + 2'h1;
			end
			ST_PSUSP:
			begin
				// Everything outside the permitted set is dropped
				if (cmd_fire && cd == `CMD_PROG_RESUME && !st_reg.alternate_space_overlay)
				begin
					st_next.state = ST_PROG;
					st_next.sr[`SR_PROG_SUSP] = 1'b0;
				end
				else if (cmd_fire && cd == `CMD_SET_EXIT)
					st_next.alternate_space_overlay = 1'b0;
				else
					st_next.state = ST_PSUSP;
			end
			ST_SETUP:
			begin
				if (cmd_fire)
					st_next.state = (cd == `UNLOCK1_DATA &&
						ca[`UNLOCK_ADDR_W-1:0] == `UNLOCK1_ADDR) ? ST_SETUP_U1 : ST_IDLE;
			end
			ST_SETUP_U1:
			begin
				if (cmd_fire)
					st_next.state = (cd == `UNLOCK2_DATA &&
						ca[`UNLOCK_ADDR_W-1:0] == `UNLOCK2_ADDR) ? ST_SETUP_U2 : ST_IDLE;
			end
			ST_SETUP_U2:
			begin
				if (cmd_fire)
				begin
					st_next.state = ST_IDLE;
					if (cd == `CMD_CHIP_ERASE)
					begin
						st_next.state = ST_CHIP_ERASE;
						// Every sector starts over; only sectors that finish regain the flag
						st_next.erase_ok = '0;
						st_next.sector = 7'h00;
						st_next.phase = 2'h0;
						st_next.timer = `SECTOR_PHASE_CYC;
					end
				end
			end
			ST_CHIP_ERASE:
			begin
				// Commands are not decoded here; per sector: preprogram, verify, erase
				if (st_reg.vlock[st_reg.sector] || st_reg.plock[st_reg.sector] ||
					(st_reg.phase == 2'h2 && st_reg.timer == 16'h0000))
				begin
					if (!(st_reg.vlock[st_reg.sector] || st_reg.plock[st_reg.sector]))
					begin
						st_next.erase_ok[st_reg.sector] = 1'b1;
						st_next.dirty[st_reg.sector] = 1'b0;
					end
					st_next.phase = 2'h0;
					st_next.timer = `SECTOR_PHASE_CYC;
					st_next.sector = st_reg.sector + 7'h01;
					if (st_reg.sector == 7'(`NUM_SECT - 1))
						st_next.state = ST_IDLE;
				end
				else if (st_reg.timer == 16'h0000)
				begin
					st_next.phase = st_reg.phase + 2'h1;
					st_next.timer = `SECTOR_PHASE_CYC;
				end
				else
					st_next.timer = st_reg.timer - 16'h0001;
			end
			ST_BLANK:
			begin
				// Halts at the first programmed location
				if (st_reg.dirty[st_reg.sector])
				begin
					st_next.state = ST_IDLE;
					st_next.sr[`SR_ERASE_FAIL] = 1'b1;
				end
				else if (st_reg.timer == 16'h0000)
				begin
					st_next.state = ST_IDLE;
					st_next.sr[`SR_ERASE_FAIL] = 1'b0;
				end
				else
					st_next.timer = st_reg.timer - 16'h0001;
			end
			ST_VERIFY:
			begin
				if (st_reg.timer == 16'h0000)
				begin
					st_next.state = ST_IDLE;
					st_next.sr[`SR_ERASE_OK] = st_reg.erase_ok[st_reg.sector];
				end
				else
					st_next.timer = st_reg.timer - 16'h0001;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	// Hardware reset ends any algorithm and restarts recovery
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			st_reg <= RESET_ST;
		else
			st_reg <= st_next;
	end

	// Program buffer storage; unloaded words read as erased via valid bits
	always_ff @(posedge clk_i)
	begin
		if (buf_we)
			buf_mem[ca[7:0]] <= cd;
	end

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.dat;
	assign ready_o = ready;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_confirm;
		st_reg.state == ST_BUF_CONF && cmd_fire && cd == `CMD_BUF_CONFIRM && sect_hit && !locked;
	endsequence
	sequence s_suspend;
		st_reg.state == ST_PROG && cmd_fire && cd == `CMD_PROG_SUSPEND && !st_reg.alternate_space_overlay;
	endsequence

	property p_unlock_order;
		st_reg.state == ST_IDLE && cmd_fire && cd == `UNLOCK2_DATA |=> st_reg.state != ST_UNLK2;
	endproperty
	a_unlock_order: assert property (p_unlock_order) else $error("unlock out of order");

	property p_count_abort;
		st_reg.state == ST_BUF_CNT && cmd_fire && cd > `MAX_WORD_COUNT |=>
			st_reg.state == ST_IDLE && st_reg.sr[`SR_PROG_FAIL] && st_reg.sr[`SR_BUF_ABORT];
	endproperty
	a_count_abort: assert property (p_count_abort) else $error("count abort missed");

	property p_confirm_busy;
		s_confirm |=> st_reg.state == ST_PROG && !ready_o;
	endproperty
	a_confirm_busy: assert property (p_confirm_busy) else $error("confirm not busy");

	property p_not_confirm_abort;
		st_reg.state == ST_BUF_CONF && cmd_fire && cd != `CMD_BUF_CONFIRM |=>
			st_reg.state == ST_IDLE && st_reg.sr[`SR_BUF_ABORT] && st_reg.sr[`SR_PROG_FAIL];
	endproperty
	a_not_confirm_abort: assert property (p_not_confirm_abort) else $error("no abort");

	property p_suspend_latency;
		s_suspend |=> st_reg.state == ST_SUSP_WAIT ##[1:5] st_reg.sr[`SR_PROG_SUSP];
	endproperty
	a_suspend_latency: assert property (p_suspend_latency) else $error("slow suspend");

	property p_resume;
		st_reg.state == ST_PSUSP && cmd_fire && cd == `CMD_PROG_RESUME && !st_reg.alternate_space_overlay |=>
			st_reg.state == ST_PROG && !st_reg.sr[`SR_PROG_SUSP];
	endproperty
	a_resume: assert property (p_resume) else $error("resume failed");

	property p_suspend_ignore;
		st_reg.state == ST_PSUSP && cmd_fire && cd != `CMD_PROG_RESUME |=>
			st_reg.state == ST_PSUSP && $stable(st_reg.sr);
	endproperty
	a_suspend_ignore: assert property (p_suspend_ignore) else $error("suspend disturbed");

	property p_aso_block;
		st_reg.state == ST_PROG && st_reg.alternate_space_overlay && cmd_fire && cd == `CMD_PROG_SUSPEND |=>
			st_reg.state inside {ST_PROG, ST_IDLE};
	endproperty
	a_aso_block: assert property (p_aso_block) else $error("suspend in overlay");

	property p_blank_busy;
		st_reg.state == ST_BLANK |-> !ready_o && !read_ok;
	endproperty
	a_blank_busy: assert property (p_blank_busy) else $error("blank check ready");

	property p_erase_ignore;
		st_reg.state == ST_CHIP_ERASE && cmd_fire |=> st_reg.state inside {ST_CHIP_ERASE, ST_IDLE};
	endproperty
	a_erase_ignore: assert property (p_erase_ignore) else $error("erase interrupted");

endmodule // flash_program_erase_sequencer

/* File: verification/host_model.sv */
// Wishbone master standing in for the host controller
`timescale 1ns/1ps
module host_model
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output flash_seq_pkg::wb_req_s req_o
);
	import flash_seq_pkg::*;
	// Bus idle from time zero
	initial req_o = '0;
	// One classic cycle, held until ack, then one idle cycle; only the bench timeout ends a wait
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		do
		begin
			@(posedge clk_i);
		end
		while (ack_i !== 1'b1);
		q = dat_i;
		req_o <= '0;
		@(posedge clk_i);
	endtask
endmodule // host_model

/* File: verification/flash_program_erase_sequencer_test.sv */
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
`include "flash_seq_map.svh"
module flash_program_erase_sequencer_test;
	import flash_seq_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	wb_req_s wb_req;
	logic wb_ack;
	logic [31:0] wb_dat;
	logic ready;
	logic [31:0] q;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	// 25 MHz clock
	initial forever #20 clk_i = ~clk_i;
	flash_program_erase_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
		.wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .ready_o(ready));
	host_model host (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_dat), .req_o(wb_req));
	task automatic check(input string name, input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", name, e, g);
		end
	endtask
	// One flash write cycle: address then data
	task automatic cmd(input logic [23:0] a, input logic [15:0] d);
		host.xfer(1'b1, `REG_CMD_ADDR, {8'h00, a}, q);
		host.xfer(1'b1, `REG_CMD_DATA, {16'h0000, d}, q);
	endtask
	task automatic unlock;
		cmd(24'h000555, `UNLOCK1_DATA);
		cmd(24'h0002aa, `UNLOCK2_DATA);
	endtask
	// Bounded wait for ready, then one status bit
	task automatic sr(input string name, input int b, input logic e);
		for (int n = 0; n < 5000 && ready !== 1'b1; n++)
			@(posedge clk_i);
		host.xfer(1'b0, `REG_STATUS, 32'h0, q);
		check(name, e, q[b]);
	endtask
	// Two words in sector 1, line 0x0203; sector address bits only
	task automatic t_program;
		host.xfer(1'b1, `REG_CTRL, 32'h00000002, q);
		unlock();
		cmd(24'h021234, `CMD_BUF_LOAD);
		cmd(24'h020000, 16'h0001);
		cmd(24'h020310, 16'h1234);
		cmd(24'h020311, 16'h5678);
		cmd(24'h02ffff, `CMD_BUF_CONFIRM);
		check("busy", 1'b0, ready);
		cmd(24'h000000, `CMD_PROG_SUSPEND);
		sr("ready", `SR_READY, 1'b1);
		sr("fail", `SR_PROG_FAIL, 1'b0);
		sr("overlay suspend", `SR_PROG_SUSP, 1'b0);
		host.xfer(1'b1, `REG_CTRL, 32'h00000000, q);
		$display("test program done");
	endtask
	// One-word program suspended, prodded, then resumed twice in a row
	task automatic t_suspend;
		unlock();
		cmd(24'h020000, `CMD_BUF_LOAD);
		cmd(24'h020000, 16'h0000);
		cmd(24'h020400, 16'h0001);
		cmd(24'h020000, `CMD_BUF_CONFIRM);
		cmd(24'h0fffff, `CMD_PROG_SUSPEND);
		sr("suspended", `SR_PROG_SUSP, 1'b1);
		cmd(24'h000555, `UNLOCK1_DATA);
		sr("still suspended", `SR_PROG_SUSP, 1'b1);
		host.xfer(1'b1, `REG_CTRL, 32'h00000002, q);
		host.xfer(1'b0, `REG_CTRL, 32'h00000000, q);
		check("overlay", 1'b0, q[1]);
		host.xfer(1'b1, `REG_READ_ADDR, 32'h00020400, q);
		host.xfer(1'b0, `REG_READ_OK, 32'h00000000, q);
		check("line read", 1'b0, q[0]);
		cmd(24'h000000, `CMD_PROG_RESUME);
		cmd(24'h000000, `CMD_PROG_RESUME);
		sr("resumed", `SR_PROG_SUSP, 1'b0);
		$display("test suspend done");
	endtask
	// Write (a, d) breaks the sequence right after the first word; an oversized count c aborts before it
	task automatic t_abort(input logic [15:0] c, input logic [23:0] a, input logic [15:0] d);
		unlock();
		cmd(24'h040000, `CMD_BUF_LOAD);
		cmd(24'h040000, c);
		cmd(24'h040020, 16'h00aa);
		cmd(a, d);
		sr("abort", `SR_BUF_ABORT, 1'b1);
		sr("fail", `SR_PROG_FAIL, 1'b1);
		$display("test abort done");
	endtask
	// Blank check, chip erase with sector 3 locked, verify
	task automatic t_erase;
		cmd(24'h020555, `CMD_BLANK_CHECK);
		sr("not blank", `SR_ERASE_FAIL, 1'b1);
		host.xfer(1'b1, `REG_LOCK_SEL, 32'h3, q);
		host.xfer(1'b1, `REG_LOCK, 32'h1, q);
		unlock();
		cmd(24'h000555, `CMD_ERASE_SETUP);
		unlock();
		cmd(24'h000555, `CMD_CHIP_ERASE);
		cmd(24'h020555, `CMD_BLANK_CHECK);
		check("erasing", 1'b0, ready);
		sr("erased", `SR_READY, 1'b1);
		cmd(24'h020000, `CMD_ERASE_VERIFY);
		sr("erase ok", `SR_ERASE_OK, 1'b1);
		cmd(24'h060000, `CMD_ERASE_VERIFY);
		sr("locked", `SR_ERASE_OK, 1'b0);
		cmd(24'h020555, `CMD_BLANK_CHECK);
		sr("blank", `SR_ERASE_FAIL, 1'b0);
		$display("test erase done");
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard: far above the few thousand cycles the tests need
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 50000)
		begin
			mismatches++;
			end_sim();
		end
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("recovery", 1'b0, ready);
		sr("idle", `SR_READY, 1'b1);
		t_abort(16'h0000, 24'h040000, `CMD_STATUS_READ);
		t_program();
		t_abort(16'h0100, 24'h040000, 16'h0000);
		t_suspend();
		t_abort(16'h0001, 24'h040120, 16'h0055);
		t_erase();
		end_sim();
	end
endmodule // flash_program_erase_sequencer_test
